// >>> hw/mmc_sd_read_path_fifo.sv
// card data buffer, dma/cpu event logic and read command token sender
`timescale 1ns/1ps
`include "sd_fifo_defines.svh"
module mmc_sd_read_path_fifo
    import sd_fifo_pkg::*;
#(
    parameter int DEPTH = `FIFO_DEPTH,
    parameter int PW    = `PTR_W
) (
    input  wire logic        sys_clk,         // function clock
    input  wire logic        nrst,            // async reset, low
    input  wire logic        linkClk,         // memory clock toward card
    input  wire logic        dirWrite,        // 1 card write, 0 card read
    input  wire logic        dmaMode,         // 1 dma driven, 0 cpu driven
    input  wire logic        bufferReset,     // clears buffer and counters
    input  wire logic [1:0]  access_width_sel, // width code 00..11
    input  wire logic [6:0]  buffer_threshold_level, // bytes per event
    input  wire logic [15:0] block_length_reg, // bytes per block
    input  wire logic [15:0] block_count_reg,  // blocks per transfer
    input  wire bus_word_t   txWord,          // tx_data_reg write
    input  wire logic        rxRead,          // rx_data_reg read strobe
    input  wire logic [1:0]  rxSize,          // read width minus one
    output logic [31:0]      rxData,          // rx_data_reg contents
    input  wire logic        dmaDone,         // dma finished its transfer
    input  wire logic        cardRxValid,     // byte from card engine
    input  wire logic [7:0]  cardRxByte,      // received byte
    output logic             cardRxStall,     // hold card reception
    input  wire logic        cardTxTake,      // card engine takes a byte
    output logic [7:0]       cardTxByte,      // byte to card engine
    output logic             cardTxUnderflow, // take while empty
    output logic             buffer_full_flag,  // status_reg_second
    output logic             buffer_empty_flag, // status_reg_second
    output logic             rx_ready_flag,   // status_reg_first
    output logic             tx_ready_flag,   // status_reg_first
    output logic             rx_ready_irq,    // one-cycle pulse
    output logic             tx_ready_irq,    // one-cycle pulse
    output logic             dmaRdEvent,      // dma read request pulse
    output logic             dmaWrEvent,      // dma write request pulse
    output logic             dmaRdIrq,        // dma read request interrupt
    output logic             dmaWrIrq,        // dma write request interrupt
    input  wire logic        sendRead,        // start read command token
    input  wire logic [31:0] readAddr,        // read command argument
    output logic             cmdBusy,         // token in flight
    output logic             cmdOut,          // command line out
    output logic             cmdOe            // command line enable
);
    typedef struct packed {
        logic [PW-1:0] wp;
        logic [PW-1:0] rp;
        logic [6:0]    rxCnt;
        logic [31:0]   total;
        logic          rdPend;
        logic          wrPend;
        logic          lastSent;
        logic          rxReady;
        logic          txReady;
        logic          rxIrq;
        logic          txIrq;
        logic          rdEv;
        logic          wrEv;
        logic [31:0]   rxData;
        logic [7:0]    txByte;
        logic          under;
        logic          reqTgl;
        logic [2:0]    ackSync;
        logic          busy;
    } st_t;
    st_t cur, next_cur;
    logic [7:0] mem [DEPTH]; // [RULE6]
    link_t      lk, next_lk;

    logic [PW-1:0] fill, n;
    logic          rxPush, txPop;
    always_comb begin
        fill = cur.wp - cur.rp;
        n = PW'(3'h4) - PW'(access_width_sel); // [RULE9] [RULE10]
    end
    // flags expressed on fill, equivalent to the pointer comparisons
    assign buffer_full_flag  = (fill + n) > PW'(DEPTH);   // [RULE9]
    assign buffer_empty_flag = fill < n;                  // [RULE10]
    assign rxPush = cardRxValid && !dirWrite && fill != PW'(DEPTH);
    assign cardRxStall = !dirWrite && fill == PW'(DEPTH); // [RULE14]
    assign txPop = cardTxTake && dirWrite && fill != '0;  // [RULE21]

    always_comb begin
        logic [PW-1:0] popN;
        logic [31:0]   word;
        logic          thr, last;
        popN = '0;
        word = '0;
        thr = 1'b0;
        last = 1'b0;
        next_cur = cur;
        next_cur.rxIrq = 1'b0;
        next_cur.txIrq = 1'b0;
        next_cur.rdEv = 1'b0;
        next_cur.wrEv = 1'b0;
        next_cur.under = cardTxTake && dirWrite && fill == '0; // [RULE21]
        if (txWord.valid && dirWrite) begin // [RULE8] [RULE11]
            for (int i = 0; i < 4; i++) begin
                if (i <= int'(txWord.size))
                    next_cur.wp = next_cur.wp + PW'(1'b1); // [RULE7]
            end
        end
        if (rxPush) begin
            next_cur.wp = cur.wp + PW'(1'b1);
            next_cur.rxCnt = cur.rxCnt + 7'h1;
            next_cur.total = cur.total + 32'h1;
        end
        if (rxRead && !dirWrite) begin // [RULE8] [RULE12]
            for (int i = 0; i < 4; i++) begin
                if (i <= int'(rxSize) && PW'(i) < fill) begin
                    word[8*i +: 8] = mem[cur.rp[PW-2:0] + (PW-1)'(i)]; // [RULE7]
                    popN = popN + PW'(1'b1);
                end
            end
            next_cur.rp = cur.rp + popN;
            next_cur.rxData = word;
            next_cur.rxReady = 1'b0; // [RULE24]
        end
        if (txPop) begin
            next_cur.txByte = mem[cur.rp[PW-2:0]];
            next_cur.rp = cur.rp + PW'(1'b1);
        end
        thr = rxPush && (cur.rxCnt + 7'h1) == buffer_threshold_level;
        last = rxPush && (cur.total + 32'h1)
               == 32'(block_length_reg) * 32'(block_count_reg);
        if (dmaDone) begin
            next_cur.rdPend = 1'b0; // [RULE13]
            next_cur.wrPend = 1'b0; // [RULE20]
        end
        if (!dirWrite && (last || (thr && !(dmaMode && cur.rdPend)))) begin
            next_cur.rdEv = dmaMode;          // [RULE13] [RULE15]
            next_cur.rdPend = dmaMode;
            next_cur.rxCnt = '0;              // [RULE23]
            next_cur.rxIrq = 1'b1;            // [RULE16] [RULE17] [RULE19]
            next_cur.rxReady = 1'b1;          // set wins over read clear
        end
        if (dirWrite && fill < PW'(buffer_threshold_level) && !cur.wrPend && dmaMode
            && !dmaDone && !bufferReset) begin
            next_cur.wrEv = 1'b1;   // [RULE20]
            next_cur.wrPend = 1'b1;
            next_cur.txIrq = 1'b1;  // [RULE22]
            next_cur.txReady = 1'b1;
        end
        if (dirWrite && !dmaMode && fill < PW'(buffer_threshold_level)
            && !cur.txReady) begin
            next_cur.txIrq = 1'b1;
            next_cur.txReady = 1'b1;
        end
        if (txWord.valid && dirWrite && !next_cur.wrEv)
            next_cur.txReady = 1'b0;
        // command start request handed to link domain by toggle
        next_cur.ackSync = {cur.ackSync[1:0], lk.doneTgl};
        if (sendRead && !cur.busy) begin // [RULE2]
            next_cur.reqTgl = ~cur.reqTgl;
            next_cur.busy = 1'b1;
        end else if (cur.ackSync[2] != cur.ackSync[1]) begin
            next_cur.busy = 1'b0;
        end
        if (bufferReset) begin
            next_cur.wp = '0;
            next_cur.rp = '0;
            next_cur.rxCnt = '0;
            next_cur.total = '0;
            next_cur.rdPend = 1'b0;
            next_cur.wrPend = 1'b0;
        end
    end

    always_ff @(posedge sys_clk or negedge nrst) begin
        if (!nrst)
            cur <= '0;
        else
            cur <= next_cur;
    end

    // storage has no reset; contents are don't-care until written
    always_ff @(posedge sys_clk) begin
        if (rxPush)
            mem[cur.wp[PW-2:0]] <= cardRxByte;
        if (txWord.valid && dirWrite && !bufferReset) begin
            for (int i = 0; i < 4; i++) begin
                if (i <= int'(txWord.size))
                    mem[cur.wp[PW-2:0] + (PW-1)'(i)] <= txWord.data[8*i +: 8]; // [RULE7]
            end
        end
    end

    assign rxData          = cur.rxData;
    assign cardTxByte      = cur.txByte;
    assign cardTxUnderflow = cur.under;
    assign rx_ready_flag   = cur.rxReady;
    assign tx_ready_flag   = cur.txReady;
    assign rx_ready_irq    = cur.rxIrq;
    assign tx_ready_irq    = cur.txIrq;
    assign dmaRdEvent      = cur.rdEv;
    assign dmaWrEvent      = cur.wrEv;
    assign dmaRdIrq        = cur.rdEv;  // [RULE13]
    assign dmaWrIrq        = cur.wrEv;  // [RULE22]
    assign cmdBusy         = cur.busy;

    // link domain: shifts the six byte read token out msb first
    logic [2:0] reqSync, next_reqSync;
    always_comb begin
        next_lk = lk;
        next_reqSync = {reqSync[1:0], cur.reqTgl};
        // argument is stable while busy, so sampling it here is safe
        if (reqSync[2] != reqSync[1] && !lk.busy) begin
            next_lk.shreg = {`CMD_START | 8'(`CMD_READ_IDX), readAddr, `CMD_STOP}; // [RULE3]
            next_lk.bits = 6'(8 * `TOKEN_BYTES);
            next_lk.busy = 1'b1;
        end else if (lk.busy) begin
            next_lk.shreg = {lk.shreg[46:0], 1'b1};
            next_lk.bits = lk.bits - 6'h1;
            if (lk.bits == 6'h1) begin
                next_lk.busy = 1'b0;
                next_lk.doneTgl = ~lk.doneTgl;
            end
        end
    end
    always_ff @(posedge linkClk or negedge nrst) begin
        if (!nrst) begin
            lk <= '0;
            reqSync <= '0;
        end else begin
            lk <= next_lk;
            reqSync <= next_reqSync;
        end
    end
    assign cmdOut = lk.busy ? lk.shreg[47] : 1'b1;
    assign cmdOe  = lk.busy;
endmodule

// >>> hw/sd_fifo_defines.svh
// constants and contract list for the card data buffer
//
// Contract
// [RULE1] software matches host and card block length before any read
// [RULE2] read order: CSD request, optional block length, select, then read command
// [RULE3] single-block read request goes out as a six byte command token
// [RULE4] card answers the read command with an R1 response before data
// [RULE5] card frames each block with start bit, payload, two CRC bytes, end bit
// [RULE6] one shared buffer of 64 byte entries serves reads and writes
// [RULE7] word to byte conversion is little-endian, low byte first
// [RULE8] transmit register writes push, receive register reads pop, cpu or dma alike
// [RULE9] full when write pointer plus N exceeds read pointer, N from width code
// [RULE10] empty when write pointer minus N is below read pointer, N from width code
// [RULE11] data registers take 32-bit words, card side moves one byte at a time
// [RULE12] cpu reads of the receive register may be one to four bytes wide
// [RULE13] read count reaching threshold issues a dma read event, blocked until done
// [RULE14] buffer keeps capturing while event pending, stalls card when full
// [RULE15] final byte of the transfer issues a draining dma read event
// [RULE16] every dma read event raises receive-ready interrupt and flag
// [RULE17] cpu reads: threshold count raises receive-ready interrupt and flag
// [RULE18] software reads threshold bytes promptly after receive-ready
// [RULE19] cpu reads: last data of transfer also raises receive-ready interrupt
// [RULE20] writes: fill below threshold issues dma write event, blocked until done
// [RULE21] writes keep feeding the card engine and signal underflow when empty
// [RULE22] every dma write event raises write and transmit-ready interrupts and flag
// [RULE23] received byte counter clears whenever a read event is generated
// [RULE24] reading the receive register clears the receive-ready flag
// [RULE25] software prefills the buffer before posting a write command
`ifndef SD_FIFO_DEFINES_SVH
`define SD_FIFO_DEFINES_SVH
`define FIFO_DEPTH     64
`define PTR_W          7
`define CMD_READ_IDX   6'h11
`define CMD_START      8'h40
`define CMD_STOP       8'h01
`define TOKEN_BYTES    3'h6
`endif

// >>> hw/sd_fifo_pkg.sv
// types for the card data buffer
package sd_fifo_pkg;
    typedef enum logic [1:0] {wd4, wd3, wd2, wd1} width_t;
    typedef struct packed {
        logic        valid;
        logic [31:0] data;
        logic [1:0]  size;    // bytes minus one
    } bus_word_t;
    typedef enum {cmdIdle, cmdShift, cmdDone} cmd_state_t;
    typedef struct packed {
        logic [47:0] shreg;
        logic [5:0]  bits;
        logic        busy;
        logic        doneTgl;
    } link_t;
endpackage

// >>> verif/card_model.sv
// card engine stand-in: offers read bytes, takes write bytes, captures the token
`timescale 1ns/1ps
module card_model (
    input  wire logic  sys_clk,     // function clock
    input  wire logic  linkClk,     // card clock
    input  wire logic  cardRxStall, // buffer full
    input  wire logic  cmdOut,      // command line
    input  wire logic  cmdOe,       // command enable
    output logic       cardRxValid, // byte offered
    output logic [7:0] cardRxByte,  // offered byte
    output logic       cardTxTake   // byte taken
);
    int          rxLeft = 0;
    int          takeLeft = 0;
    bit          slow = 0;
    bit          phase = 0;
    logic [7:0]  nxt = 8'h00;
    logic [47:0] token = 48'h0;
    initial begin
        cardRxValid = 1'b0;
        cardRxByte = 8'h00;
        cardTxTake = 1'b0;
    end
    always @(posedge sys_clk) begin
        // a byte offered while full is dropped by the buffer, so offer it again
        // bytes come framed-off: start, crc and end bits are the card engine's job
        if (cardRxValid && !cardRxStall) begin
            rxLeft--;
            nxt++;
        end
        if (cardTxTake)
            takeLeft--;
        #1;
        phase = !phase;
        cardRxValid = rxLeft > 0 && (!slow || phase);
        cardRxByte = cardRxValid ? nxt : ~cardRxByte;
        cardTxTake = takeLeft > 0;
    end
    always @(posedge linkClk)
        // the r1 answer to the captured token is left to the card engine
        if (cmdOe)
            token <= {token[46:0], cmdOut};
endmodule

// >>> verif/sd_fifo_chk.sv
// bound assertions for the card data buffer ports
`timescale 1ns/1ps
module sd_fifo_chk (
    input wire logic       sys_clk, nrst, cardRxValid, cardRxStall, rxRead, // clock, reset, data
    input wire logic       buffer_full_flag, buffer_empty_flag, rx_ready_flag, rx_ready_irq,
    input wire logic       dmaRdEvent, dmaRdIrq, dmaWrEvent, dmaWrIrq, tx_ready_irq,
    input wire logic       tx_ready_flag, dmaMode, dirWrite, cmdOut, cmdOe, // modes, command
    input wire logic [1:0] access_width_sel // width code
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!nrst);
    property p_rdEv; dmaRdEvent |-> dmaRdIrq && rx_ready_irq && rx_ready_flag; endproperty
    a_rdEv: assert property (p_rdEv) else $error("read event lacks its notices");
    property p_rdDir; dmaRdEvent |-> dmaMode && !dirWrite; endproperty
    a_rdDir: assert property (p_rdDir) else $error("read event outside dma read");
    property p_wrEv; dmaWrEvent |-> dmaWrIrq && tx_ready_irq && tx_ready_flag; endproperty
    a_wrEv: assert property (p_wrEv) else $error("write event lacks its notices");
    property p_wrDir; dmaWrEvent |-> dmaMode && dirWrite; endproperty
    a_wrDir: assert property (p_wrDir) else $error("write event outside dma write");
    property p_rxRise; $rose(rx_ready_flag) |-> rx_ready_irq; endproperty
    a_rxRise: assert property (p_rxRise) else $error("rx flag set silently");
    property p_txRise; $rose(tx_ready_flag) |-> tx_ready_irq; endproperty
    a_txRise: assert property (p_txRise) else $error("tx flag set silently");
    property p_clr; rxRead && !cardRxValid && !dirWrite |=> !rx_ready_flag; endproperty
    a_clr: assert property (p_clr) else $error("rx flag kept after read");
    property p_stall; cardRxStall |-> buffer_full_flag && !buffer_empty_flag; endproperty
    a_stall: assert property (p_stall) else $error("stall without full");
    property p_full1;
        access_width_sel == 2'h3 && !dirWrite |-> buffer_full_flag == cardRxStall;
    endproperty
    a_full1: assert property (p_full1) else $error("single width full wrong");
    property p_idle; !cmdOe |-> cmdOut; endproperty
    a_idle: assert property (p_idle) else $error("command line not idle high");
    c_rdEv: cover property (dmaRdEvent);
    c_wrEv: cover property (dmaWrEvent);
    c_stall: cover property (cardRxStall);
endmodule
bind mmc_sd_read_path_fifo sd_fifo_chk i_chk (.*);

// >>> verif/testbench.sv
// self-checking bench for the card data buffer
`timescale 1ns/1ps
module testbench;
    import sd_fifo_pkg::*;
    logic        sys_clk = 0, nrst = 0, linkClk = 0, dirWrite = 0, dmaMode = 0, bufferReset = 0;
    logic        rxRead = 0, dmaDone = 0, sendRead = 0, cardRxValid, cardRxStall, cardTxTake;
    logic        cardTxUnderflow, buffer_full_flag, buffer_empty_flag, rx_ready_flag;
    logic        tx_ready_flag, rx_ready_irq, tx_ready_irq, dmaRdEvent, dmaWrEvent, dmaRdIrq;
    logic        dmaWrIrq, cmdBusy, cmdOut, cmdOe;
    logic [1:0]  access_width_sel = 2'h0, rxSize = 2'h0;
    logic [6:0]  buffer_threshold_level = 7'h08;
    logic [15:0] block_length_reg = 16'h0001, block_count_reg = 16'h0001;
    logic [31:0] readAddr = 32'h0, rxData, rxQ[$];
    logic [7:0]  cardRxByte, cardTxByte, eb[$], txQ[$];
    bus_word_t   txWord = '0;
    int          badCount = 0, numChecks = 0, seed = 92, nIrq, nRdEv, nWrEv, nUf;
    bit          rdv = 0, txv = 0;
    always #5 sys_clk = ~sys_clk;
    initial begin
        #3.7;
        forever #6 linkClk = ~linkClk;
    end
    mmc_sd_read_path_fifo i_dut (.*);
    card_model i_card (.*);
    task automatic chk(input string nm, input logic [31:0] seen, want);
        numChecks++;
        if (seen !== want) begin
            badCount++;
            $display("CHECK FAILED %s expected %h seen %h", nm, want, seen);
        end
    endtask
    task automatic finishTest();
        $display("checks %0d mismatches %0d", numChecks, badCount);
        if (badCount == 0 && numChecks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic tick(int n = 1);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic start(bit w, bit d, logic [6:0] thr, logic [15:0] len, cnt);
        {dirWrite, dmaMode, buffer_threshold_level} = {w, d, thr};
        {block_length_reg, block_count_reg} = {len, cnt};
        bufferReset = 1;
        tick(2);
        bufferReset = 0;
        {nIrq, nRdEv, nWrEv, nUf} = '0;
    endtask
    task automatic send(int n, bit sl);
        logic [7:0] b;
        b = 8'($random(seed));
        for (int i = 0; i < n; i++) eb.push_back(b + i[7:0]);
        {i_card.nxt, i_card.slow, i_card.rxLeft} = {b, sl, n};
    endtask
    // bounded wait for the card side to reach a count
    task automatic waitLeft(int n);
        int k;
        for (k = 0; k < 3000 && (i_card.rxLeft != n || i_card.takeLeft != 0); k++) tick();
        if (k == 3000) begin
            badCount++;
            finishTest();
        end
        tick(3);
    endtask
    task automatic rd(logic [1:0] sz);
        logic [31:0] w;
        w = '0;
        for (int i = 0; i <= sz; i++) w[i*8 +: 8] = eb.pop_front();
        rxQ.push_back(w);
        {rxSize, rxRead} = {sz, 1'b1};
        tick();
    endtask
    task automatic wr(logic [1:0] sz);
        logic [31:0] w;
        w = $random(seed);
        for (int i = 0; i <= sz; i++) txQ.push_back(w[i*8 +: 8]);
        txWord = '{1'b1, w, sz};
        tick();
    endtask
    task automatic flags(int fill);
        for (int c = 0; c < 4; c++) begin
            access_width_sel = c[1:0];
            #1;
            chk("full", buffer_full_flag, fill + 4 - c > 64);
            chk("empty", buffer_empty_flag, fill < 4 - c);
            tick();
        end
    endtask
    always @(posedge sys_clk) begin
        if (rdv)
            chk("rxData", rxData, rxQ.pop_front());
        if (txv && txQ.size() > 0)
            chk("cardTxByte", cardTxByte, txQ.pop_front());
        {rdv, txv} = {rxRead, cardTxTake};
        nIrq += rx_ready_irq;
        nRdEv += dmaRdEvent;
        nWrEv += dmaWrEvent;
        nUf += cardTxUnderflow;
    end
    initial begin
        int k;
        tick(8);
        nrst = 1;
        chk("cmdOut", cmdOut, 1);
        tick();
        start(0, 0, 7'h08, 16'h000a, 16'h0001);
        send(10, 0);
        waitLeft(0);
        chk("rxIrqs", nIrq, 2);
        chk("rxFlag", rx_ready_flag, 1);
        rd(2'h3);
        rd(2'h0);
        rd(2'h1);
        rxRead = 0;
        chk("rxFlag", rx_ready_flag, 0);
        flags(3);
        rd(2'h2);
        rxRead = 0;
        flags(0);
        start(0, 1, 7'h20, 16'h0014, 16'h0002);
        send(40, 1);
        waitLeft(0);
        chk("rdEvents", nRdEv, 2);
        chk("rxIrqs", nIrq, 2);
        for (int i = 0; i < 10; i++) rd(2'h3);
        {rxRead, dmaDone} = 2'h1;
        tick();
        dmaDone = 0;
        start(0, 0, 7'h40, 16'h0046, 16'h0001);
        send(70, 0);
        waitLeft(6);
        chk("stall", cardRxStall, 1);
        flags(64);
        rd(2'h0);
        for (int i = 0; i < 17; i++) rd(2'h3);
        rd(2'h0);
        rxRead = 0;
        tick(2);
        chk("rxIrqs", nIrq, 2);
        start(1, 1, 7'h08, 16'h0008, 16'h0001);
        wr(2'h3);
        wr(2'h1);
        txWord.valid = 0;
        i_card.takeLeft = 7;
        waitLeft(0);
        chk("underflow", nUf, 1);
        chk("wrEvents", nWrEv, 1);
        dmaDone = 1;
        tick();
        dmaDone = 0;
        tick(3);
        chk("wrEvents", nWrEv, 2);
        readAddr = $random(seed);
        sendRead = 1;
        tick();
        sendRead = 0;
        chk("busy", cmdBusy, 1);
        for (k = 0; k < 300 && cmdBusy !== 1'b0; k++) tick();
        chk("busyEnd", cmdBusy, 0);
        chk("token", i_card.token === {8'h51, readAddr, 8'h01}, 1);
        finishTest();
    end
endmodule
